// [pkg/trfc_regs.vh]
// Constants of the temperature result formatter
`ifndef TRFC_REGS_VH
`define TRFC_REGS_VH
`define TRFC_RES_14 2'h0
`define TRFC_RES_12 2'h1
`define TRFC_RES_13 2'h2
`define TRFC_RES_11 2'h3
`define TRFC_RES_RESET 2'h0
`define TRFC_STAT_TYPE_BIT 1
`define TRFC_STAT_FREE_BIT 0
`define TRFC_TYPE_TEMP 1'h0
`define TRFC_BYTE_BITS 4'h8
`define TRFC_LOWSUP_RESET 1'h0
`endif

// [hdl/trfc_result_tx.v]
// Temperature result formatter and serial byte shifter with acknowledge slots
`include "trfc_regs.vh"
// Operation
// - Results come at 14-bit resolution after reset until another is selected.
// - A 16-bit result goes as two bytes, high byte first, or as the high byte only if the host nacks it.
// - Bits within each byte leave most significant first, left aligned.
// - An acknowledge slot follows every result byte before next byte or end.
// - Low-supply flag is refreshed once per completed measurement only.
// - Two lowest bits carry status; upper is type, zero for temperature.
// - Low-supply flag set below 2.25 V threshold, cleared above it.
module trfc_result_tx #(
  parameter RAW_W = 14
) (
  input wire CORE_CLK_IN,
  input wire RESETN_IN,
  input wire CLK_EN_IN,
  input wire [1:0] RES_SEL_IN,
  input wire RES_SEL_WR_IN,
  input wire MEAS_DONE_IN,
  input wire [RAW_W-1:0] MEAS_RAW_IN,
  input wire SUPPLY_LOW_IN,
  input wire START_TX_IN,
  input wire LINK_SCL_IN,
  input wire LINK_SDA_IN,
  output reg LINK_SDA_OUT,
  output reg LINK_SDA_OE_N_OUT,
  output reg [1:0] RES_OUT,
  output reg LOW_SUPPLY_OUT,
  output reg [15:0] RESULT_OUT,
  output reg TX_BUSY_OUT,
  output reg HOST_ACK_OUT,
  output reg TX_DONE_OUT
);
  localparam ST_IDLE = 4'h1;
  localparam ST_DATA = 4'h2;
  localparam ST_ACK = 4'h4;
  localparam ST_END = 4'h8;

  reg [3:0] state_reg;
  reg [2:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg [1:0] sup_sync_reg;
  reg [3:0] bit_cnt_reg;
  reg byte_sel_reg;
  reg [15:0] shift_word_reg;
  wire scl_fall;
  wire scl_rise;
  wire [15:0] aligned_word;

  // Left-justify the raw value to 14 bits of temperature then status pair
  function [15:0] trfc_pack;
    input [RAW_W-1:0] raw;
    input [1:0] res;
    reg [13:0] t;
    begin
      t = raw[RAW_W-1 -: 14];
      // Coarser settings zero the unused low bits; formula stays the same
      case (res)
        `TRFC_RES_12: t = {t[13:2], 2'h0};
        `TRFC_RES_13: t = {t[13:1], 1'h0};
        `TRFC_RES_11: t = {t[13:3], 3'h0};
        default: t = t;
      endcase
      trfc_pack = {t, `TRFC_TYPE_TEMP, 1'h0};
    end
  endfunction

  assign aligned_word = trfc_pack(MEAS_RAW_IN, RES_OUT);
  // Only the synchronised stages feed edge detection
  assign scl_fall = scl_sync_reg[2] & ~scl_sync_reg[1];
  assign scl_rise = ~scl_sync_reg[2] & scl_sync_reg[1];

  // Pin synchronisers, two stages before any logic
  always @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 2'h3;
      sup_sync_reg <= 2'h0;
    end else if (CLK_EN_IN) begin
      scl_sync_reg <= {scl_sync_reg[1:0], LINK_SCL_IN};
      sda_sync_reg <= {sda_sync_reg[0], LINK_SDA_IN};
      sup_sync_reg <= {sup_sync_reg[0], SUPPLY_LOW_IN};
    end
  end

  // Resolution setting and per-measurement result capture
  always @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      RES_OUT <= `TRFC_RES_RESET;
      LOW_SUPPLY_OUT <= `TRFC_LOWSUP_RESET;
      RESULT_OUT <= 16'h0000;
    end else if (CLK_EN_IN) begin
      if (RES_SEL_WR_IN)
        RES_OUT <= RES_SEL_IN;
      // Flag sampled only at completion, so supply dips between runs are unseen
      if (MEAS_DONE_IN) begin
        LOW_SUPPLY_OUT <= sup_sync_reg[1];
        RESULT_OUT <= aligned_word;
      end
    end
  end

  // Byte shifter: data changes on SCL fall, host ack sampled on SCL rise
  always @(posedge CORE_CLK_IN) begin
    if (!RESETN_IN) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      byte_sel_reg <= 1'h0;
      shift_word_reg <= 16'h0000;
      LINK_SDA_OUT <= 1'h1;
      LINK_SDA_OE_N_OUT <= 1'h1;
      TX_BUSY_OUT <= 1'h0;
      HOST_ACK_OUT <= 1'h0;
      TX_DONE_OUT <= 1'h0;
    end else if (CLK_EN_IN) begin
      TX_DONE_OUT <= 1'h0;
      case (state_reg)
        ST_IDLE: begin
          LINK_SDA_OE_N_OUT <= 1'h1;
          if (START_TX_IN) begin
            shift_word_reg <= RESULT_OUT;
            byte_sel_reg <= 1'h0;
            bit_cnt_reg <= 4'h0;
            TX_BUSY_OUT <= 1'h1;
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (scl_fall) begin
            if (bit_cnt_reg == `TRFC_BYTE_BITS) begin
              LINK_SDA_OE_N_OUT <= 1'h1; // Release for host ack
              state_reg <= ST_ACK;
            end else begin
              LINK_SDA_OUT <= shift_word_reg[15];
              LINK_SDA_OE_N_OUT <= 1'h0;
              shift_word_reg <= {shift_word_reg[14:0], 1'h0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_ACK: begin
          if (scl_rise) begin
            HOST_ACK_OUT <= ~sda_sync_reg[1];
            bit_cnt_reg <= 4'h0;
            // Nack or second byte ends transfer; high byte went first
            if (byte_sel_reg || sda_sync_reg[1]) begin
              state_reg <= ST_END;
            end else begin
              byte_sel_reg <= 1'h1;
              state_reg <= ST_DATA;
            end
          end
        end
        ST_END: begin
          TX_BUSY_OUT <= 1'h0;
          TX_DONE_OUT <= 1'h1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// [sim/trfc_chk.sv]
// Port checker for the result formatter
module trfc_chk (
  input wire CORE_CLK_IN, RESETN_IN, RES_SEL_WR_IN, MEAS_DONE_IN, SUPPLY_LOW_IN, START_TX_IN,
  input wire LINK_SDA_OE_N_OUT, LOW_SUPPLY_OUT, TX_BUSY_OUT, TX_DONE_OUT,
  input wire [1:0] RES_OUT,
  input wire [15:0] RESULT_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_res_default: assert property ($rose(RESETN_IN) |-> RES_OUT == 2'h0)
    else $error("resolution not 14 bit after reset");
  a_res_hold: assert property (!RES_SEL_WR_IN |=> $stable(RES_OUT))
    else $error("resolution changed without a write");
  a_low_hold: assert property (!MEAS_DONE_IN |=> $stable(LOW_SUPPLY_OUT))
    else $error("supply flag moved between measurements");
  a_low_track: assert property (MEAS_DONE_IN && $past(SUPPLY_LOW_IN, 3) == SUPPLY_LOW_IN
    && $stable(SUPPLY_LOW_IN) |=> LOW_SUPPLY_OUT == $past(SUPPLY_LOW_IN))
    else $error("supply flag wrong after measurement");
  a_stat_zero: assert property (RESULT_OUT[1:0] == 2'h0)
    else $error("status bits not zero");
  a_idle_release: assert property (!TX_BUSY_OUT |-> LINK_SDA_OE_N_OUT)
    else $error("data line driven while idle");
  a_start_busy: assert property (START_TX_IN && !TX_BUSY_OUT |=> TX_BUSY_OUT)
    else $error("start not taken");
  a_done_pulse: assert property (TX_DONE_OUT |-> $fell(TX_BUSY_OUT) ##1 !TX_DONE_OUT)
    else $error("done pulse malformed");
  cover property (TX_DONE_OUT);
  cover property (MEAS_DONE_IN && SUPPLY_LOW_IN);
  cover property (RES_SEL_WR_IN);
endmodule
bind trfc_result_tx trfc_chk CHK (.*);

// [sim/trfc_host.sv]
// Two-wire host model reading one result
module trfc_host (output logic scl = 1, output logic sda_h = 1, input wire sda);
  timeunit 1ns; timeprecision 1ps;
  // Low and high phases of 16 ns; pull-up wins once released
  task automatic rd(input logic ack1, output logic [15:0] d);
    d = 16'h0;
    for (int i = 0; i < 18; i++) begin
      #16 scl = 0;
      sda_h = (i == 8) ? !ack1 : 1'b1;
      #16 scl = 1;
      if (i % 9 < 8) d = {d[14:0], sda};
      if (i == 8 && !ack1) break;
    end
  endtask
endmodule

// [sim/tb.sv]
// Bench for the result formatter with a two-wire host model
module tb;
  timeunit 1ns; timeprecision 1ps;
  logic clk = 0, rst_n = 0, wr = 0, md = 0, sup = 0, st = 0;
  logic [1:0] sel = 2'h0;
  logic [13:0] raw = 14'h0;
  wire scl, sda_h, sdo, oe_n, busy, ack, done, lows;
  wire [1:0] res;
  wire [15:0] rslt;
  wire sda = (oe_n | sdo) & sda_h; // Open drain with pull-up
  int n_fail = 0, compares = 0, cyc = 0;
  always #2 clk = ~clk;
  trfc_result_tx DUT (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .CLK_EN_IN(1'b1), .RES_SEL_IN(sel),
    .RES_SEL_WR_IN(wr), .MEAS_DONE_IN(md), .MEAS_RAW_IN(raw), .SUPPLY_LOW_IN(sup),
    .START_TX_IN(st), .LINK_SCL_IN(scl), .LINK_SDA_IN(sda), .LINK_SDA_OUT(sdo),
    .LINK_SDA_OE_N_OUT(oe_n), .RES_OUT(res), .LOW_SUPPLY_OUT(lows), .RESULT_OUT(rslt),
    .TX_BUSY_OUT(busy), .HOST_ACK_OUT(ack), .TX_DONE_OUT(done));
  trfc_host HOST (.scl(scl), .sda_h(sda_h), .sda(sda));
  task chk(input string n, input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One resolution: convert, hold flag, send with early or late nack
  task t_conv(input logic [1:0] s, input logic a1, lo);
    logic [15:0] e, d;
    int z, tc;
    z = s == 2'h1 ? 4 : s == 2'h2 ? 3 : s == 2'h3 ? 5 : 2;
    e = (16'h635c >> z) << z;
    sel = s; wr = 1; sup = lo; raw = 14'h18d7; step(1); wr = 0; step(4);
    md = 1; step(1); md = 0; step(1);
    chk("res", res, s);
    chk("result", rslt, e);
    sup = ~lo; step(4);
    chk("lowsup", lows, lo);
    st = 1; step(1); st = 0;
    HOST.rd(a1, d);
    if (a1) chk("masked", d & 16'hfffc, e);
    else chk("byte1", d[7:0], e[15:8]);
    // Host side conversion in hundredths of a degree, status bits cleared first
    tc = (17572 * int'(d & 16'hfffc)) / 65536 - 4685;
    if (a1 && s == 2'h0) chk("celsius", tc[15:0], 16'd2135);
    for (int i = 0; i < 20 && done !== 1'b1; i++) step(1);
    chk("done", done, 1);
    chk("last_ack", ack, 0);
    $display("t_conv %h finished", s);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    step(16); rst_n = 1; step(1);
    chk("res0", res, 0);
    t_conv(2'h0, 1, 0); t_conv(2'h1, 0, 1); t_conv(2'h2, 1, 1); t_conv(2'h3, 1, 0);
    end_of_test;
  end
endmodule
